// [design/autoneg_partner_nextpage_regs.sv]
// negotiation partner ability, expansion status and next-page transmit registers
//
// Contract
// - bit 15 shows partner page kind, read-only
// - bit 14 shows partner acknowledged local word
// - bit 13 shows partner remote fault, resets 0
// - bit 11 mirrors partner asymmetric pause when enabled
// - bit 10 shows partner pause support
// - bits 9,8,6 show partner T4/TX-full/Te-full
// - bit 7 set by advertised or detected 100TX
// - bit 5 set by advertised or detected 10Te-half
// - bits 4:0 hold partner selector, reset zero
// - parallel detect fault sticky, clears on read
// - expansion bit 3 shows partner next-page ability
// - expansion bit 2 local next-page ability, reset 1
// - page received sticky, clears on read
// - bit 0 partner negotiation capable when enabled
// - more-pages bit writable, sent unchanged
// - comply flag writable, resets 0
// - toggle bit inverse of previous sent toggle
// - code field writable reset 0x1, mode bit 13
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_regs.svh"

module autoneg_partner_nextpage_regs (
    input wire logic CLOCK,
    input wire logic RESET,
    // management register port from the serial frame decoder
    input wire autoneg_pkg::reg_addr_t REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire autoneg_pkg::mii_word_t REG_WDATA,
    output autoneg_pkg::mii_word_t REG_RDATA,
    output logic REG_RVALID,
    // line-side negotiation engine
    input wire logic AN_ENABLE,
    input wire logic LINK_RESTART,
    input wire logic PARTNER_PAGE_VALID,
    input wire autoneg_pkg::mii_word_t PARTNER_PAGE,
    input wire logic PARTNER_SENDING_NEXT,
    input wire logic PARTNER_AN_CAPABLE,
    input wire logic PARALLEL_LINK_100TX,
    input wire logic PARALLEL_LINK_10TE,
    input wire logic PARALLEL_FAULT,
    input wire logic NP_SENT,
    output autoneg_pkg::mii_word_t NP_TX_WORD
);
    import autoneg_pkg::*;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic hit_partner; // partner ability word selected
    logic hit_expansion; // expansion status selected
    logic hit_np; // next-page transmit word selected

    // plain comparisons against the three offsets; only one can hit,
    // every other address reads zero and has writes dropped
    always_comb begin
        hit_partner = 1'b0;
        hit_expansion = 1'b0;
        hit_np = 1'b0;
        if (REG_ADDR == `PARTNER_ABILITY_OFFSET) begin
            hit_partner = 1'b1;
        end else if (REG_ADDR == `EXPANSION_STATUS_OFFSET) begin
            hit_expansion = 1'b1;
        end else if (REG_ADDR == `NP_TRANSMIT_OFFSET) begin
            hit_np = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // partner ability word
    // ----------------------------------------------------------------
    logic pa_next_reg; // partner is on a protocol-specific page
    logic pa_ack_reg; // partner acknowledged our word
    logic pa_fault_reg; // partner signals remote fault
    logic pa_asym_reg; // partner asymmetric pause
    logic pa_pause_reg; // partner pause
    logic pa_t4_reg; // partner 100Base-T4
    logic pa_tx_full_reg; // partner 100Base-TX full duplex
    logic pa_tx_half_reg; // partner 100Base-TX
    logic pa_te_full_reg; // partner 10Base-Te full duplex
    logic pa_te_half_reg; // partner 10Base-Te half duplex
    logic [4:0] pa_selector_reg; // partner selector field
    logic partner_np_reg; // partner next-page able

    // link restart clears every partner field so abilities from an
    // earlier negotiation never survive into the next one
    // base-page kind tracks the engine's phase
    always_ff @(posedge CLOCK) begin
        if (RESET || LINK_RESTART) begin
            pa_next_reg <= 1'b0;
        end else if (PARTNER_PAGE_VALID) begin
            pa_next_reg <= PARTNER_SENDING_NEXT;
        end
    end

    // a protocol-specific page carries no abilities, so it must not
    // overwrite what the primary page delivered
    // base-page fields captured only from the primary page
    always_ff @(posedge CLOCK) begin
        if (RESET || LINK_RESTART) begin
            pa_ack_reg <= 1'b0;
            pa_fault_reg <= 1'b0;
            pa_asym_reg <= 1'b0;
            pa_pause_reg <= 1'b0;
            pa_t4_reg <= 1'b0;
            pa_tx_full_reg <= 1'b0;
            pa_te_full_reg <= 1'b0;
            pa_selector_reg <= `PA_SELECTOR_RESET;
            partner_np_reg <= 1'b0;
        end else if (PARTNER_PAGE_VALID && !PARTNER_SENDING_NEXT) begin
            pa_ack_reg <= PARTNER_PAGE[`PA_ACK_BIT];
            pa_fault_reg <= PARTNER_PAGE[`PA_REMOTE_FAULT_BIT];
            pa_asym_reg <= PARTNER_PAGE[`PA_ASYM_PAUSE_BIT];
            pa_pause_reg <= PARTNER_PAGE[`PA_PAUSE_BIT];
            pa_t4_reg <= PARTNER_PAGE[`PA_T4_BIT];
            pa_tx_full_reg <= PARTNER_PAGE[`PA_TX_FULL_BIT];
            pa_te_full_reg <= PARTNER_PAGE[`PA_TE_FULL_BIT];
            pa_selector_reg <= PARTNER_PAGE[`PA_SELECTOR_MSB:0];
            partner_np_reg <= PARTNER_PAGE[`PA_NEXT_PAGE_BIT];
        end
    end

    // half-duplex bits also come from a parallel-detected link
    // a parallel-detected link wins over a page load in the same cycle
    always_ff @(posedge CLOCK) begin
        if (RESET || LINK_RESTART) begin
            pa_tx_half_reg <= 1'b0;
            pa_te_half_reg <= 1'b0;
        end else begin
            if (PARALLEL_LINK_100TX) begin
                pa_tx_half_reg <= 1'b1;
            end else if (PARTNER_PAGE_VALID && !PARTNER_SENDING_NEXT) begin
                pa_tx_half_reg <= PARTNER_PAGE[`PA_TX_HALF_BIT];
            end
            if (PARALLEL_LINK_10TE) begin
                pa_te_half_reg <= 1'b1;
            end else if (PARTNER_PAGE_VALID && !PARTNER_SENDING_NEXT) begin
                pa_te_half_reg <= PARTNER_PAGE[`PA_TE_HALF_BIT];
            end
        end
    end

    // assembled read value; bit 12 reserved reads zero
    mii_word_t partner_word;
    always_comb begin
        partner_word = 16'h0000;
        partner_word[`PA_NEXT_PAGE_BIT] = pa_next_reg;
        partner_word[`PA_ACK_BIT] = pa_ack_reg;
        partner_word[`PA_REMOTE_FAULT_BIT] = pa_fault_reg;
        partner_word[`PA_ASYM_PAUSE_BIT] = pa_asym_reg & AN_ENABLE;
        partner_word[`PA_PAUSE_BIT] = pa_pause_reg;
        partner_word[`PA_T4_BIT] = pa_t4_reg;
        partner_word[`PA_TX_FULL_BIT] = pa_tx_full_reg;
        partner_word[`PA_TX_HALF_BIT] = pa_tx_half_reg;
        partner_word[`PA_TE_FULL_BIT] = pa_te_full_reg;
        partner_word[`PA_TE_HALF_BIT] = pa_te_half_reg;
        partner_word[`PA_SELECTOR_MSB:0] = pa_selector_reg;
    end

    // ----------------------------------------------------------------
    // expansion status
    // ----------------------------------------------------------------
    logic exp_read; // software read of the expansion register
    logic pd_fault_flag; // parallel detection fault, sticky
    logic page_rx_flag; // new page received, sticky

    // the flags survive a link restart: only device reset or a read of
    // the expansion register clears them
    assign exp_read = REG_READ & hit_expansion;

    // fault flag, set wins over the clearing read
    sticky_read_clear u_pd_fault (
        .clk(CLOCK),
        .rst(RESET),
        .set_pulse(PARALLEL_FAULT),
        .read_clear(exp_read),
        .flag(pd_fault_flag)
    );

    // page-received flag, set wins over the clearing read
    sticky_read_clear u_page_rx (
        .clk(CLOCK),
        .rst(RESET),
        .set_pulse(PARTNER_PAGE_VALID),
        .read_clear(exp_read),
        .flag(page_rx_flag)
    );

    // assembled read value; bits 15:5 reserved read zero
    mii_word_t expansion_word;
    always_comb begin
        expansion_word = 16'h0000;
        expansion_word[`EX_PD_FAULT_BIT] = pd_fault_flag;
        expansion_word[`EX_PARTNER_NP_BIT] = partner_np_reg;
        expansion_word[`EX_LOCAL_NP_BIT] = `EX_LOCAL_NP_RESET;
        expansion_word[`EX_PAGE_RX_BIT] = page_rx_flag;
        expansion_word[`EX_PARTNER_AN_BIT] = PARTNER_AN_CAPABLE & AN_ENABLE;
    end

    // ----------------------------------------------------------------
    // next-page transmit word
    // ----------------------------------------------------------------
    logic np_write; // software write of the next-page word
    logic np_more_reg; // further pages follow
    logic page_mode_select_reg; // 1 message page, 0 unformatted
    logic message_comply_flag_reg; // local node will comply
    logic toggle_reg; // inverse of last sent toggle
    page_code_t page_code_field_reg; // message or unformatted code

    assign np_write = REG_WRITE & hit_np;

    // software owns these fields, so a link restart leaves them untouched; only the toggle is cleared
    // writable fields; bits 14 and 11 ignore writes
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            np_more_reg <= `NP_MORE_PAGES_RESET;
            page_mode_select_reg <= `NP_PAGE_MODE_RESET;
            message_comply_flag_reg <= `NP_COMPLY_RESET;
            page_code_field_reg <= `NP_CODE_RESET;
        end else if (np_write) begin
            np_more_reg <= REG_WDATA[`NP_MORE_PAGES_BIT];
            page_mode_select_reg <= REG_WDATA[`NP_PAGE_MODE_BIT];
            message_comply_flag_reg <= REG_WDATA[`NP_COMPLY_BIT];
            page_code_field_reg <= REG_WDATA[`NP_CODE_MSB:0];
        end
    end

    // toggle flips after each code word the engine sends
    // the engine pulses page-sent once per exchanged code word
    always_ff @(posedge CLOCK) begin
        if (RESET || LINK_RESTART) begin
            toggle_reg <= `NP_TOGGLE_RESET;
        end else if (NP_SENT) begin
            toggle_reg <= ~toggle_reg;
        end
    end

    // word as read and as handed to the engine, unchanged
    mii_word_t np_word;
    always_comb begin
        np_word = 16'h0000;
        np_word[`NP_MORE_PAGES_BIT] = np_more_reg;
        np_word[`NP_PAGE_MODE_BIT] = page_mode_select_reg;
        np_word[`NP_COMPLY_BIT] = message_comply_flag_reg;
        np_word[`NP_TOGGLE_BIT] = toggle_reg;
        np_word[`NP_CODE_MSB:0] = page_code_field_reg;
    end

    // registered copy for the line side
    // the register keeps the line side off the management write path
    // at the cost of one cycle of lag
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            NP_TX_WORD <= {`NP_MORE_PAGES_RESET, 1'b0, `NP_PAGE_MODE_RESET, `NP_COMPLY_RESET,
                `NP_TOGGLE_RESET, `NP_CODE_RESET};
        end else begin
            NP_TX_WORD <= np_word;
        end
    end

    // ----------------------------------------------------------------
    // read data path
    // ----------------------------------------------------------------
    mii_word_t read_mux; // selected register value

    // unmapped addresses read zero
    always_comb begin
        read_mux = 16'h0000;
        if (hit_partner) begin
            read_mux = partner_word;
        end else if (hit_expansion) begin
            read_mux = expansion_word;
        end else if (hit_np) begin
            read_mux = np_word;
        end
    end

    // the read captures the word in its own cycle, so a flag cleared by
    // that read still returns its set value
    // sample before the clear takes effect
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_READ) begin
            REG_RDATA <= read_mux;
        end
    end

    // one-cycle marker that read data is fresh
    // no wait states: data always follows a read strobe by one cycle
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_READ;
        end
    end

endmodule : autoneg_partner_nextpage_regs

`default_nettype wire

// [design/autoneg_pkg.sv]
// types shared by the negotiation register bank
package autoneg_pkg;
    typedef logic [15:0] mii_word_t; // one 16-bit management register
    typedef logic [4:0] reg_addr_t; // management register address
    typedef logic [10:0] page_code_t; // message or unformatted code field
endpackage : autoneg_pkg

// [design/autoneg_regs.svh]
// offsets, field positions, reset values of the negotiation status and next-page registers
`ifndef AUTONEG_REGS_SVH
`define AUTONEG_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the management register port
// ----------------------------------------------------------------
`define PARTNER_ABILITY_OFFSET 5'h05
`define EXPANSION_STATUS_OFFSET 5'h06
`define NP_TRANSMIT_OFFSET 5'h07

// ----------------------------------------------------------------
// partner ability word field positions
// ----------------------------------------------------------------
`define PA_NEXT_PAGE_BIT 15
`define PA_ACK_BIT 14
`define PA_REMOTE_FAULT_BIT 13
`define PA_ASYM_PAUSE_BIT 11
`define PA_PAUSE_BIT 10
`define PA_T4_BIT 9
`define PA_TX_FULL_BIT 8
`define PA_TX_HALF_BIT 7
`define PA_TE_FULL_BIT 6
`define PA_TE_HALF_BIT 5
`define PA_SELECTOR_MSB 4
`define PA_SELECTOR_RESET 5'h00

// ----------------------------------------------------------------
// expansion status field positions and reset values
// ----------------------------------------------------------------
`define EX_PD_FAULT_BIT 4
`define EX_PARTNER_NP_BIT 3
`define EX_LOCAL_NP_BIT 2
`define EX_PAGE_RX_BIT 1
`define EX_PARTNER_AN_BIT 0
`define EX_LOCAL_NP_RESET 1'b1

// ----------------------------------------------------------------
// next-page transmit word field positions and reset values
// ----------------------------------------------------------------
`define NP_MORE_PAGES_BIT 15
`define NP_PAGE_MODE_BIT 13
`define NP_COMPLY_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10
`define NP_CODE_RESET 11'h001
`define NP_MORE_PAGES_RESET 1'b0
`define NP_PAGE_MODE_RESET 1'b0
`define NP_COMPLY_RESET 1'b0
`define NP_TOGGLE_RESET 1'b0

`endif

// [design/sticky_read_clear.sv]
// one sticky status flag that is set by hardware and cleared by a register read
`timescale 1ns/1ps
`default_nettype none

module sticky_read_clear (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_pulse,
    input wire logic read_clear,
    output logic flag
);

    // ----------------------------------------------------------------
    // flag storage
    // ----------------------------------------------------------------
    logic flag_reg; // held event

    // set wins over clear so an event in the read cycle is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (set_pulse) begin
            flag_reg <= 1'b1;
        end else if (read_clear) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;

endmodule : sticky_read_clear

`default_nettype wire

// [tb/autoneg_regs_checker_properties.sv]
// concurrent checks on the negotiation register bank ports
`timescale 1ns/1ps
`default_nettype none
module autoneg_regs_checker
    import autoneg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire autoneg_pkg::reg_addr_t REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire autoneg_pkg::mii_word_t REG_WDATA,
    input wire autoneg_pkg::mii_word_t REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic AN_ENABLE,
    input wire logic LINK_RESTART,
    input wire logic PARTNER_PAGE_VALID,
    input wire autoneg_pkg::mii_word_t PARTNER_PAGE,
    input wire logic PARTNER_SENDING_NEXT,
    input wire logic PARTNER_AN_CAPABLE,
    input wire logic PARALLEL_FAULT,
    input wire logic NP_SENT,
    input wire autoneg_pkg::mii_word_t NP_TX_WORD
);
    // ----------------------------------------------------------------
    // decoded strobes and flag-setting events
    // ----------------------------------------------------------------
    logic rd5, rd6, wr7, evt;
    assign rd5 = REG_READ && REG_ADDR == 5'h05;
    assign rd6 = REG_READ && REG_ADDR == 5'h06;
    assign wr7 = REG_WRITE && REG_ADDR == 5'h07;
    assign evt = PARALLEL_FAULT || PARTNER_PAGE_VALID;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    chk_rvalid_pulse: assert property (REG_RVALID == $past(REG_READ))
        else $error("read valid not one cycle after read strobe");
    chk_local_np: assert property (rd6 |=> REG_RDATA[2] && REG_RDATA[15:5] == 11'h000)
        else $error("expansion local next-page or reserved bits wrong");
    chk_an_capable: assert property (rd6 |=> REG_RDATA[0] == ($past(AN_ENABLE) && $past(PARTNER_AN_CAPABLE)))
        else $error("partner negotiation capable bit wrong");
    chk_pause_gate: assert property (rd5 && !AN_ENABLE |=> !REG_RDATA[11])
        else $error("asymmetric pause shown while negotiation off");
    chk_fault_sticky: assert property (PARALLEL_FAULT ##1 !rd6 ##1 rd6 |=> REG_RDATA[4])
        else $error("parallel fault flag not set");
    chk_page_flag: assert property (PARTNER_PAGE_VALID ##1 !rd6 [*3] ##1 rd6 |=> REG_RDATA[1])
        else $error("page received flag not set");
    chk_read_clears: assert property (rd6 && !evt ##1 !evt ##1 rd6 |=> !REG_RDATA[4] && !REG_RDATA[1])
        else $error("sticky flag survived its read");
    chk_page_load: assert property (PARTNER_PAGE_VALID && !LINK_RESTART ##1 !PARTNER_PAGE_VALID
        && !LINK_RESTART ##1 rd5 |=> REG_RDATA[15] == $past(PARTNER_SENDING_NEXT, 3)
        && ($past(PARTNER_SENDING_NEXT, 3) || ((REG_RDATA ^ $past(PARTNER_PAGE, 3)) & 16'h001f) == 16'h0000))
        else $error("partner page kind or selector wrong");
    chk_np_write: assert property (wr7 ##1 !wr7 |=> (NP_TX_WORD & 16'hb7ff) == ($past(REG_WDATA, 2) & 16'hb7ff))
        else $error("next-page word not sent as written");
    chk_toggle_cause: assert property ($changed(NP_TX_WORD[11]) |-> $past(NP_SENT, 2) || $past(LINK_RESTART, 2) || $past(RESET, 2))
        else $error("toggle bit moved without a sent page");
endmodule : autoneg_regs_checker
bind autoneg_partner_nextpage_regs autoneg_regs_checker checker_inst (.CLOCK, .RESET, .REG_ADDR,
    .REG_WRITE, .REG_READ, .REG_WDATA, .REG_RDATA, .REG_RVALID, .AN_ENABLE, .LINK_RESTART,
    .PARTNER_PAGE_VALID, .PARTNER_PAGE, .PARTNER_SENDING_NEXT, .PARTNER_AN_CAPABLE,
    .PARALLEL_FAULT, .NP_SENT, .NP_TX_WORD);
`default_nettype wire

// [tb/line_engine_model.sv]
// line-side negotiation engine model: partner pages, fault and page-sent strobes
`timescale 1ns/1ps
`default_nettype none
module line_engine_model (
    input wire logic clock,
    output logic page_valid,
    output autoneg_pkg::mii_word_t page,
    output logic sending_next,
    output logic pd_fault,
    output logic np_sent
);
    import autoneg_pkg::*;
    // idle levels at time zero
    initial begin
        page_valid = 1'b0;
        page = 16'h0000;
        sending_next = 1'b0;
        pd_fault = 1'b0;
        np_sent = 1'b0;
    end
    // one page per call; lines carry garbage once the page is taken
    task send_page(input mii_word_t w, input logic nxt);
        @(posedge clock);
        page_valid <= 1'b1;
        page <= w;
        sending_next <= nxt;
        @(posedge clock);
        page_valid <= 1'b0;
        page <= ~w;
        sending_next <= ~nxt;
    endtask : send_page
    // one-cycle strobe: 0 parallel fault, 1 next page sent
    task strobe(input logic which);
        @(posedge clock);
        pd_fault <= !which;
        np_sent <= which;
        @(posedge clock);
        pd_fault <= 1'b0;
        np_sent <= 1'b0;
    endtask : strobe
endmodule : line_engine_model
`default_nettype wire

// [tb/tb_autoneg_partner_nextpage_regs.sv]
// self-checking bench for the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_partner_nextpage_regs;
    import autoneg_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ----------------------------------------------------------------
    logic clock, reset, reg_write, reg_read, an_enable, link_restart, an_capable, an, cap, tog;
    logic link_100tx, link_10te, page_valid, sending_next, pd_fault, np_sent, reg_rvalid;
    reg_addr_t reg_addr;
    mii_word_t reg_wdata, reg_rdata, np_tx_word, page, w, d;
    int mismatches = 0, compares = 0, cycles = 0, seed;
    autoneg_partner_nextpage_regs uut (.CLOCK(clock), .RESET(reset), .REG_ADDR(reg_addr),
        .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .AN_ENABLE(an_enable),
        .LINK_RESTART(link_restart), .PARTNER_PAGE_VALID(page_valid), .PARTNER_PAGE(page),
        .PARTNER_SENDING_NEXT(sending_next), .PARTNER_AN_CAPABLE(an_capable),
        .PARALLEL_LINK_100TX(link_100tx), .PARALLEL_LINK_10TE(link_10te),
        .PARALLEL_FAULT(pd_fault), .NP_SENT(np_sent), .NP_TX_WORD(np_tx_word));
    line_engine_model mdl (.clock(clock), .page_valid(page_valid), .page(page),
        .sending_next(sending_next), .pd_fault(pd_fault), .np_sent(np_sent));
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            results();
        end
    end
    // expected partner word: reserved bit clear, page kind, pause gated by enable
    function automatic mii_word_t exp_partner(mii_word_t v, logic nxt, logic en);
        exp_partner = v & 16'hefff;
        exp_partner[15] = nxt;
        exp_partner[11] = v[11] & en;
    endfunction : exp_partner
    // expected next-page word: read-only bits masked, toggle inserted
    function automatic mii_word_t exp_np(mii_word_t v, logic t);
        exp_np = (v & 16'hb7ff) | {4'h0, t, 11'h000};
    endfunction : exp_np
    task check(input mii_word_t seen, input mii_word_t exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input reg_addr_t a, input mii_word_t v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    // read strobe, then compare data in the valid cycle
    task rd(input reg_addr_t a, input mii_word_t e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check({15'h0000, reg_rvalid}, 16'h0001);
        check(reg_rdata, e);
    endtask : rd
    task results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        {reset, reg_write, reg_read, an_enable, link_restart, an_capable} = 6'h3f & 6'h20;
        {link_100tx, link_10te} = 2'h0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        seed = 32'h0000_42a9;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        rd(5'h07, 16'h0001);
        check(np_tx_word, 16'h0001);
        for (int i = 5; i < 9; i++) begin
            wr(5'(i), 16'hffff);
        end
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        rd(5'h08, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'hffff : 16'($random(seed));
            an = (i == 0) ? 1'b1 : 1'($random(seed));
            cap = 1'($random(seed));
            @(posedge clock);
            an_enable <= an;
            an_capable <= cap;
            mdl.send_page(w, 1'b0);
            rd(5'h05, exp_partner(w, 1'b0, an));
            rd(5'h06, {11'h000, 1'b0, w[15], 2'h3, an & cap});
            rd(5'h06, {11'h000, 1'b0, w[15], 2'h2, an & cap});
            mdl.send_page(~w, 1'b1);
            rd(5'h05, exp_partner(w, 1'b1, an));
        end
        mdl.strobe(1'b0);
        rd(5'h06, {11'h000, 1'b1, w[15], 2'h3, an & cap});
        rd(5'h06, {11'h000, 1'b0, w[15], 2'h2, an & cap});
        @(posedge clock);
        {link_100tx, link_10te} <= 2'h3;
        @(posedge clock);
        {link_100tx, link_10te} <= 2'h0;
        rd(5'h05, exp_partner(w, 1'b1, an) | 16'h00a0);
        tog = 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = (i == 3) ? 16'hffff : 16'($random(seed));
            d[13] = i[0];
            wr(5'h07, d);
            rd(5'h07, exp_np(d, tog));
            check(np_tx_word, exp_np(d, tog));
            mdl.strobe(1'b1);
            tog = ~tog;
            rd(5'h07, exp_np(d, tog));
        end
        // link restart clears partner fields and toggle, keeps the software word
        mdl.strobe(1'b1);
        @(posedge clock);
        link_restart <= 1'b1;
        @(posedge clock);
        link_restart <= 1'b0;
        rd(5'h07, exp_np(d, 1'b0));
        rd(5'h05, 16'h0000);
        rd(5'h06, {11'h000, 1'b0, 1'b0, 2'h2, an & cap});
        results();
    end
endmodule : tb_autoneg_partner_nextpage_regs
`default_nettype wire
